// [logic/at_handler_regs.svh]
`ifndef AT_HANDLER_REGS_SVH
`define AT_HANDLER_REGS_SVH
// ----------------------------------------
// Scan configuration field
// ----------------------------------------
`define SCAN_NONE      2'h0
`define SCAN_BOTH      2'h3
`define SCAN_INQ_BIT   0
`define SCAN_PAGE_BIT  1
`define SCAN_ARG_MAX   4'h3
// ----------------------------------------
// Production mode argument
// ----------------------------------------
`define PROD_ARG_MAX   4'h1
// ----------------------------------------
// Counts
// ----------------------------------------
`define DISC_MAX       4'h8
`define IMG_HDR_BYTES  2'h2
`define BOOT_SAMPLE    2'h3
`endif

// [logic/at_handler_pkg.sv]
package at_handler_pkg;
    // Decoded host commands
    typedef enum logic [2:0] {
        CMD_DISC_START   = 3'h0,
        CMD_SET_DISC     = 3'h1,
        CMD_IMG_DL       = 3'h2,
        CMD_TEST_EN      = 3'h3,
        CMD_PROD_MODE    = 3'h4,
        CMD_SW_RESET     = 3'h5
    } cmd_t;
    // Response codes to the host
    typedef enum logic [2:0] {
        RSP_NONE         = 3'h0,
        RSP_OK           = 3'h1,
        RSP_ERROR        = 3'h2,
        RSP_DISC_RESULT  = 3'h3,
        RSP_DISC_DONE    = 3'h4,
        RSP_DL_DONE      = 3'h5,
        RSP_NAME_SVC     = 3'h6
    } rsp_t;
    // Handler sequencing
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_DISC   = 3'h1,
        ST_DL     = 3'h2,
        ST_T_FILT = 3'h3,
        ST_T_SCAN = 3'h4,
        ST_T_DUT  = 3'h5
    } state_t;
endpackage

// [logic/image_if.sv]
`timescale 1ns/100ps
interface image_if;
    logic        start;
    logic        byteValid;
    logic [7:0]  byteData;
    logic        done;
    logic        wrValid;
    logic [15:0] wrAddr;
    logic [7:0]  wrData;
    modport ctrl   (output start, byteValid, byteData, input done, wrValid, wrAddr, wrData);
    modport loader (input start, byteValid, byteData, output done, wrValid, wrAddr, wrData);
endinterface

// [logic/image_loader.sv]
`timescale 1ns/100ps
`include "at_handler_regs.svh"
module image_loader (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    // Image stream
    image_if.loader  img
);
    logic        active_q;
    logic [1:0]  hdrCnt_q;
    logic [15:0] len_q;
    logic [15:0] cnt_q;
    logic [15:0] idx_q;
    logic        hdrDone;

    assign hdrDone = (hdrCnt_q == `IMG_HDR_BYTES);

    // ----------------------------------------
    // Header parse and byte count
    // ----------------------------------------
    // Length is big-endian, payload bytes after header
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            active_q <= 1'b0;
            hdrCnt_q <= 2'h0;
            len_q    <= 16'h0000;
            cnt_q    <= 16'h0000;
            idx_q    <= 16'h0000;
        end else if (ce) begin
            if (img.start) begin
                active_q <= 1'b1;
                hdrCnt_q <= 2'h0;
                len_q    <= 16'h0000;
                cnt_q    <= 16'h0000;
                idx_q    <= 16'h0000;
            end else if (active_q && img.byteValid) begin
                idx_q <= idx_q + 16'h0001;
                if (!hdrDone) begin
                    len_q    <= {len_q[7:0], img.byteData};
                    hdrCnt_q <= hdrCnt_q + 2'h1;
                end else begin
                    cnt_q <= cnt_q + 16'h0001;
                end
            end else if (active_q && hdrDone && cnt_q == len_q) begin
                active_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Write strobe and completion
    // ----------------------------------------
    // Done follows the cycle after the last write
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            img.wrValid <= 1'b0;
            img.wrAddr  <= 16'h0000;
            img.wrData  <= 8'h00;
            img.done    <= 1'b0;
        end else if (ce) begin
            img.wrValid <= active_q && img.byteValid && !img.start;
            img.done    <= active_q && !img.start && !img.byteValid
                           && hdrDone && cnt_q == len_q;
            if (active_q && img.byteValid) begin
                img.wrAddr <= idx_q;
                img.wrData <= img.byteData;
            end
        end
    end

    chk_done_count: assert property (@(posedge clock) disable iff (!arst_n)
        $rose(img.done) |-> $past(cnt_q) == $past(len_q) && $past(hdrDone))
        else $error("Download done before length reached");
    chk_write_once: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && active_q && img.byteValid && !img.start) |=> img.wrValid)
        else $error("Accepted image byte not written");
endmodule

// [logic/at_handler.sv]
`timescale 1ns/100ps
`include "at_handler_regs.svh"
// Functional notes
// - At most eight discovery results before done
// - Inquiry answered with name and services
// - Scan argument 0..3 selects inquiry/page scans
// - Scans persist indefinitely; command acknowledged OK
// - Scans off while linked, back on after
// - Any reset leaves no scans enabled
// - No registered service: reject connection requests unless the event filter is open
// - Download replies OK before image bytes
// - Download accepted only in production mode
// - Image live after production off, hardware reset
// - Count bytes to header length, then confirm
// - Test enable replies OK, opens event filter
// - Then both scans, then device-under-test mode; inqScan and pageScan rise on the same edge as dutMode
module at_handler (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   arst_n,
    input  wire logic                   ce,
    // Decoded host commands
    input  wire logic                   cmdValid,
    input  wire at_handler_pkg::cmd_t   cmdOp,
    input  wire logic [3:0]             cmdArg,
    // Raw image bytes from UART
    input  wire logic                   rxValid,
    input  wire logic [7:0]             rxByte,
    // Radio events
    input  wire logic                   devFound,
    input  wire logic                   discEnd,
    input  wire logic                   inquiryIn,
    input  wire logic                   connReq,
    input  wire logic                   svcRegistered,
    // Pins
    input  wire logic                   linkUp,
    input  wire logic                   nvArmed,
    // Responses to host
    output logic                        rspValid,
    output at_handler_pkg::rsp_t        rspCode,
    // Radio control
    output logic                        inqScan,
    output logic                        pageScan,
    output logic                        connAccept,
    output logic                        connReject,
    output logic                        evtFilterAll,
    output logic                        dutMode,
    // Nonvolatile image
    output logic                        nvWrValid,
    output logic [15:0]                 nvWrAddr,
    output logic [7:0]                  nvWrData,
    output logic                        imageArm,
    output logic                        imageLive
);
    at_handler_pkg::state_t state_q;
    logic [1:0]  scanCfg_q;
    logic        prodMode_q;
    logic [3:0]  discCnt_q;
    logic        dlStaged_q;
    logic        lnk1_q;
    logic        lnk2_q;
    logic        arm1_q;
    logic        arm2_q;
    logic [1:0]  bootCnt_q;
    logic        cmdOk;
    logic        cmdErr;
    logic        discShow;
    logic        connAllow;

    image_if img ();

    // Argument range check
    function automatic logic argInRange(input logic [3:0] a, input logic [3:0] lim);
        argInRange = (a <= lim);
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Two flops before any reader
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lnk1_q <= 1'b0;
            lnk2_q <= 1'b0;
            arm1_q <= 1'b0;
            arm2_q <= 1'b0;
        end else if (ce) begin
            lnk1_q <= linkUp;
            lnk2_q <= lnk1_q;
            arm1_q <= nvArmed;
            arm2_q <= arm1_q;
        end
    end

    // ----------------------------------------
    // Command acceptance
    // ----------------------------------------
    // Commands only taken when idle
    always_comb begin
        cmdOk = 1'b0;
        if (cmdValid && state_q == at_handler_pkg::ST_IDLE) begin
            unique case (cmdOp)
                at_handler_pkg::CMD_DISC_START: cmdOk = 1'b1;
                at_handler_pkg::CMD_SET_DISC:
                    cmdOk = argInRange(cmdArg, `SCAN_ARG_MAX);
                at_handler_pkg::CMD_IMG_DL:    cmdOk = prodMode_q;
                at_handler_pkg::CMD_TEST_EN:   cmdOk = 1'b1;
                at_handler_pkg::CMD_PROD_MODE:
                    cmdOk = argInRange(cmdArg, `PROD_ARG_MAX);
                at_handler_pkg::CMD_SW_RESET:  cmdOk = 1'b1;
                default:                       cmdOk = 1'b0;
            endcase
        end
    end

    assign cmdErr    = cmdValid && !cmdOk;
    assign discShow  = state_q == at_handler_pkg::ST_DISC && devFound
                       && discCnt_q < `DISC_MAX;
    assign connAllow = svcRegistered || evtFilterAll;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Idle, discovery, download and test steps
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= at_handler_pkg::ST_IDLE;
        end else if (ce) begin
            unique case (state_q)
                at_handler_pkg::ST_IDLE: begin
                    if (cmdOk && cmdOp == at_handler_pkg::CMD_DISC_START) begin
                        state_q <= at_handler_pkg::ST_DISC;
                    end else if (cmdOk && cmdOp == at_handler_pkg::CMD_IMG_DL) begin
                        state_q <= at_handler_pkg::ST_DL;
                    end else if (cmdOk && cmdOp == at_handler_pkg::CMD_TEST_EN) begin
                        state_q <= at_handler_pkg::ST_T_FILT;
                    end
                end
                at_handler_pkg::ST_DISC: begin
                    if (discEnd) begin
                        state_q <= at_handler_pkg::ST_IDLE;
                    end
                end
                at_handler_pkg::ST_DL: begin
                    if (img.done) begin
                        state_q <= at_handler_pkg::ST_IDLE;
                    end
                end
                at_handler_pkg::ST_T_FILT: state_q <= at_handler_pkg::ST_T_SCAN;
                at_handler_pkg::ST_T_SCAN: state_q <= at_handler_pkg::ST_T_DUT;
                at_handler_pkg::ST_T_DUT:  state_q <= at_handler_pkg::ST_IDLE;
                default:                   state_q <= at_handler_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Configuration state
    // ----------------------------------------
    // Scan selection and production mode
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            scanCfg_q  <= `SCAN_NONE;
            prodMode_q <= 1'b0;
        end else if (ce) begin
            if (state_q == at_handler_pkg::ST_T_SCAN) begin
                scanCfg_q <= `SCAN_BOTH;
            end else if (cmdOk && cmdOp == at_handler_pkg::CMD_SET_DISC) begin
                scanCfg_q <= cmdArg[1:0];
            end else if (cmdOk && cmdOp == at_handler_pkg::CMD_SW_RESET) begin
                scanCfg_q <= `SCAN_NONE;
            end
            if (cmdOk && cmdOp == at_handler_pkg::CMD_PROD_MODE) begin
                prodMode_q <= cmdArg[0];
            end
        end
    end

    // Test mode flags
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            evtFilterAll <= 1'b0;
            dutMode      <= 1'b0;
        end else if (ce) begin
            if (cmdOk && cmdOp == at_handler_pkg::CMD_SW_RESET) begin
                evtFilterAll <= 1'b0;
                dutMode      <= 1'b0;
            end else begin
                if (state_q == at_handler_pkg::ST_T_FILT) begin
                    evtFilterAll <= 1'b1;
                end
                if (state_q == at_handler_pkg::ST_T_DUT) begin
                    dutMode <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Radio control outputs
    // ----------------------------------------
    // Scans suspended while linked
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            inqScan    <= 1'b0;
            pageScan   <= 1'b0;
            connAccept <= 1'b0;
            connReject <= 1'b0;
        end else if (ce) begin
            inqScan    <= scanCfg_q[`SCAN_INQ_BIT] && !lnk2_q;
            pageScan   <= scanCfg_q[`SCAN_PAGE_BIT] && !lnk2_q;
            connAccept <= connReq && connAllow;
            connReject <= connReq && !connAllow;
        end
    end

    // ----------------------------------------
    // Discovery result limit
    // ----------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            discCnt_q <= 4'h0;
        end else if (ce) begin
            if (cmdOk && cmdOp == at_handler_pkg::CMD_DISC_START) begin
                discCnt_q <= 4'h0;
            end else if (discShow) begin
                discCnt_q <= discCnt_q + 4'h1;
            end
        end
    end

    // ----------------------------------------
    // Responses
    // ----------------------------------------
    // Command answer first, then events
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rspValid <= 1'b0;
            rspCode  <= at_handler_pkg::RSP_NONE;
        end else if (ce) begin
            rspValid <= 1'b1;
            if (cmdOk) begin
                rspCode <= at_handler_pkg::RSP_OK;
            end else if (cmdErr) begin
                rspCode <= at_handler_pkg::RSP_ERROR;
            end else if (img.done) begin
                rspCode <= at_handler_pkg::RSP_DL_DONE;
            end else if (state_q == at_handler_pkg::ST_DISC && discEnd) begin
                rspCode <= at_handler_pkg::RSP_DISC_DONE;
            end else if (discShow) begin
                rspCode <= at_handler_pkg::RSP_DISC_RESULT;
            end else if (inquiryIn) begin
                rspCode <= at_handler_pkg::RSP_NAME_SVC;
            end else begin
                rspValid <= 1'b0;
                rspCode  <= at_handler_pkg::RSP_NONE;
            end
        end
    end

    // ----------------------------------------
    // Image download path
    // ----------------------------------------
    // Bytes pass from the cycle in which the OK stands, after the taking edge
    assign img.start     = cmdOk && cmdOp == at_handler_pkg::CMD_IMG_DL;
    assign img.byteValid = rxValid && state_q == at_handler_pkg::ST_DL;
    assign img.byteData  = rxByte;
    assign nvWrValid     = img.wrValid;
    assign nvWrAddr      = img.wrAddr;
    assign nvWrData      = img.wrData;

    image_loader u_loader (
        .clock  (clock),
        .arst_n (arst_n),
        .ce     (ce),
        .img    (img)
    );

    // Staged image armed once production mode is off
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dlStaged_q <= 1'b0;
            imageArm   <= 1'b0;
        end else if (ce) begin
            if (img.start) begin
                dlStaged_q <= 1'b0;
            end else if (img.done) begin
                dlStaged_q <= 1'b1;
            end
            imageArm <= dlStaged_q && !prodMode_q;
        end
    end

    // Armed flag sampled once after hardware reset
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bootCnt_q <= 2'h0;
            imageLive <= 1'b0;
        end else if (ce && bootCnt_q != `BOOT_SAMPLE) begin
            bootCnt_q <= bootCnt_q + 2'h1;
            if (bootCnt_q + 2'h1 == `BOOT_SAMPLE) begin
                imageLive <= arm2_q;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_disc_limit: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && state_q == at_handler_pkg::ST_DISC && devFound && discCnt_q >= `DISC_MAX)
        |=> rspCode != at_handler_pkg::RSP_DISC_RESULT)
        else $error("More than eight discovery results");
    chk_scan_arg: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && cmdOk && cmdOp == at_handler_pkg::CMD_SET_DISC && !linkUp
         && state_q == at_handler_pkg::ST_IDLE) ##1 (ce && !cmdValid) [*3]
        |-> ##1 (lnk2_q || {pageScan, inqScan} == $past(cmdArg[1:0], 4)))
        else $error("Scan outputs differ from argument");
    chk_link_off: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && lnk2_q) |=> !inqScan && !pageScan)
        else $error("Scan active while linked");
    chk_reject_nosvc: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && connReq && !svcRegistered && !evtFilterAll) |=> connReject && !connAccept)
        else $error("Connection accepted without service");
    chk_dl_gate: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && cmdValid && cmdOp == at_handler_pkg::CMD_IMG_DL && !prodMode_q)
        |=> rspCode == at_handler_pkg::RSP_ERROR && state_q != at_handler_pkg::ST_DL)
        else $error("Download taken outside production mode");
    chk_test_order: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && state_q == at_handler_pkg::ST_T_FILT) ##1 ce ##1 ce
        |=> evtFilterAll && scanCfg_q == `SCAN_BOTH && dutMode)
        else $error("Test enable sequence out of order");
    chk_busy_error: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && cmdValid && state_q != at_handler_pkg::ST_IDLE)
        |=> rspValid && rspCode == at_handler_pkg::RSP_ERROR && $stable(scanCfg_q))
        else $error("Busy command not rejected");
    chk_name_reply: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && inquiryIn && !cmdValid && !img.done && state_q == at_handler_pkg::ST_IDLE)
        |=> rspCode == at_handler_pkg::RSP_NAME_SVC)
        else $error("Inquiry not answered");
endmodule

// [testbench/host_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Host processor model
// ----------------------------------------
module host_model (
    // Clock
    input  wire logic            clock,
    // Command strobe
    output logic                 cmdValid,
    output at_handler_pkg::cmd_t cmdOp,
    output logic [3:0]           cmdArg,
    // Raw image bytes
    output logic                 rxValid,
    output logic [7:0]           rxByte
);
    // Idle values from time zero
    initial begin
        cmdValid = 1'b0;
        cmdOp    = at_handler_pkg::CMD_SW_RESET;
        cmdArg   = 4'h0;
        rxValid  = 1'b0;
        rxByte   = 8'h00;
    end
    // One command pulse, held up to its taking edge
    task automatic cmd(input at_handler_pkg::cmd_t op, input logic [3:0] arg);
        @(posedge clock);
        #1;
        cmdValid = 1'b1;
        cmdOp    = op;
        cmdArg   = arg;
        @(posedge clock);
        #1;
        cmdValid = 1'b0;
        cmdArg   = ~arg;
    endtask
    // Image bytes back to back, four of them from the current cycle, with no wait for the OK
    task automatic bytes(input logic [7:0] b [4]);
        for (int i = 0; i < 4; i++) begin
            rxValid = 1'b1;
            rxByte  = b[i];
            @(posedge clock);
            #1;
        end
        rxValid = 1'b0;
        rxByte  = ~rxByte;
    endtask
endmodule

// [testbench/test_at_handler.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Command handler bench
// ----------------------------------------
module test_at_handler;
    logic        clock, arstN, devFound, discEnd, inquiryIn, connReq, svcRegistered;
    logic        linkUp, nvArmed, cmdValid, rxValid, rspValid, inqScan, pageScan;
    logic        connAccept, connReject, evtFilterAll, dutMode, nvWrValid, imageArm;
    logic        imageLive, ce;
    logic [3:0]  cmdArg;
    logic [7:0]  rxByte, nvWrData;
    logic [15:0] nvWrAddr;
    logic [23:0] lastWr;
    at_handler_pkg::cmd_t cmdOp;
    at_handler_pkg::rsp_t rspCode;
    int          nRsp [8];
    int          nWr, checks, nMismatch, cycles;

    host_model host (.clock(clock), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdArg(cmdArg),
        .rxValid(rxValid), .rxByte(rxByte));
    at_handler dut (.clock(clock), .arst_n(arstN), .ce(ce), .cmdValid(cmdValid),
        .cmdOp(cmdOp), .cmdArg(cmdArg), .rxValid(rxValid), .rxByte(rxByte),
        .devFound(devFound), .discEnd(discEnd), .inquiryIn(inquiryIn), .connReq(connReq),
        .svcRegistered(svcRegistered), .linkUp(linkUp), .nvArmed(nvArmed),
        .rspValid(rspValid), .rspCode(rspCode), .inqScan(inqScan), .pageScan(pageScan),
        .connAccept(connAccept), .connReject(connReject), .evtFilterAll(evtFilterAll),
        .dutMode(dutMode), .nvWrValid(nvWrValid), .nvWrAddr(nvWrAddr),
        .nvWrData(nvWrData), .imageArm(imageArm), .imageLive(imageLive));

    // Clock, cycle limit and tallies of responses and writes
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (rspValid === 1'b1) nRsp[rspCode]++;
        if (nvWrValid === 1'b1) begin
            nWr++;
            lastWr = {nvWrAddr, nvWrData};
        end
        if (cycles == 2000) begin
            nMismatch++;
            close_out();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            nMismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Command whose answer stands in the cycle after the taking edge
    task automatic cmdChk(input at_handler_pkg::cmd_t op, input logic [3:0] a,
                          input logic [2:0] exp);
        host.cmd(op, a);
        chk({rspValid, rspCode}, {1'b1, exp});
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask

    task automatic t_scan();
        for (int a = 0; a < 5; a++) begin
            cmdChk(at_handler_pkg::CMD_SET_DISC, a[3:0], a < 4 ? 3'h1 : 3'h2);
            tick(1);
            chk({pageScan, inqScan}, a < 4 ? a[1:0] : 2'h3);
        end
        tick(40);
        chk({pageScan, inqScan}, 2'h3);
        cmdChk(at_handler_pkg::CMD_SET_DISC, 4'h2, 3'h1);
        linkUp = 1'b1;
        tick(4);
        chk({pageScan, inqScan}, 2'h0);
        linkUp = 1'b0;
        tick(4);
        chk({pageScan, inqScan}, 2'h2);
        $display("scan test done");
    endtask
    task automatic t_conn();
        pulse(connReq);
        chk({connAccept, connReject}, 2'b01);
        // Clock enable low: request ignored, last answer held
        ce = 1'b0;
        pulse(connReq);
        chk({connAccept, connReject}, 2'b01);
        ce = 1'b1;
        svcRegistered = 1'b1;
        tick(1);
        pulse(connReq);
        chk({connAccept, connReject}, 2'b10);
        pulse(inquiryIn);
        chk({rspValid, rspCode}, {1'b1, 3'h6});
        $display("connect test done");
    endtask
    task automatic t_disc();
        cmdChk(at_handler_pkg::CMD_DISC_START, 4'h0, 3'h1);
        cmdChk(at_handler_pkg::CMD_SET_DISC, 4'h0, 3'h2);
        nRsp = '{default: 0};
        devFound = 1'b1;
        tick(10);
        devFound = 1'b0;
        tick(1);
        pulse(discEnd);
        tick(2);
        chk(nRsp[3], 8);
        chk(nRsp[4], 1);
        chk({pageScan, inqScan}, 2'h2);
        $display("discovery test done");
    endtask
    task automatic t_load();
        cmdChk(at_handler_pkg::CMD_IMG_DL, 4'h0, 3'h2);
        cmdChk(at_handler_pkg::CMD_PROD_MODE, 4'h2, 3'h2);
        cmdChk(at_handler_pkg::CMD_PROD_MODE, 4'h1, 3'h1);
        cmdChk(at_handler_pkg::CMD_IMG_DL, 4'h0, 3'h1);
        nWr = 0;
        nRsp = '{default: 0};
        host.bytes('{8'h00, 8'h02, 8'h5A, 8'hA5});
        tick(4);
        chk(nWr, 4);
        chk(lastWr, 24'h0003A5);
        chk(nRsp[5], 1);
        chk(imageArm, 1'b0);
        cmdChk(at_handler_pkg::CMD_PROD_MODE, 4'h0, 3'h1);
        tick(1);
        chk(imageArm, 1'b1);
        $display("download test done");
    endtask
    task automatic t_test();
        cmdChk(at_handler_pkg::CMD_SW_RESET, 4'h0, 3'h1);
        tick(1);
        chk({pageScan, inqScan}, 2'h0);
        svcRegistered = 1'b0;
        cmdChk(at_handler_pkg::CMD_TEST_EN, 4'h0, 3'h1);
        tick(1);
        chk({evtFilterAll, dutMode, pageScan}, 3'b100);
        tick(1);
        chk(dutMode, 1'b0);
        tick(1);
        chk({dutMode, pageScan, inqScan}, 3'b111);
        pulse(connReq);
        chk({connAccept, connReject}, 2'b10);
        $display("test mode test done");
    endtask
    task automatic t_hw();
        nvArmed = 1'b1;
        arstN = 1'b0;
        tick(1);
        chk({dutMode, inqScan, rspValid, imageArm}, 4'h0);
        arstN = 1'b1;
        tick(3);
        chk({imageLive, pageScan, inqScan}, 3'b100);
        $display("hardware reset test done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, nMismatch);
        if (nMismatch == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence
    initial begin
        {arstN, devFound, discEnd, inquiryIn, connReq, svcRegistered, linkUp} = 7'h00;
        nvArmed = 1'b0;
        ce = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        arstN = 1'b1;
        chk({inqScan, pageScan, dutMode, evtFilterAll, imageLive}, 5'h00);
        t_scan();
        t_conn();
        t_disc();
        t_load();
        t_test();
        t_hw();
        close_out();
    end
endmodule
